// ===== src/ssc_defines.svh
// Constants of the slow-channel sequencer: IDs, codes, timing and frame lengths
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

// ****************************************************
// Message identifiers
// ****************************************************
`define SSC_ID_ERROR 8'h01
`define SSC_ID_SENSOR_TYPE 8'h03
`define SSC_ID_MAKER 8'h05
`define SSC_ID_REVISION 8'h06
`define SSC_ID_TEMP 8'h23
`define SSC_ID_SERIAL_BASE 8'h29
`define SSC_ID_CUST_BASE 8'h07
`define SSC_ID_OEM_A_BASE 8'h90
`define SSC_ID_OEM_B_BASE 8'h94

// ****************************************************
// Data values and error word layout
// ****************************************************
`define SSC_REVISION_DATA 12'h004
`define SSC_TEMP_MIN 12'h001
`define SSC_TEMP_MAX 12'hff8
`define SSC_CODE_FUNC 12'hffa
`define SSC_CODE_SENSOR 12'hffb
`define SSC_CODE_START 12'hffe
`define SSC_CODE_ZERO 12'h000
`define SSC_ERR_MEMORY 0
`define SSC_ERR_CONVERTER 1
`define SSC_ERR_REGULATOR 2
`define SSC_ERR_CLIPPING 3
`define SSC_ERR_TEMP 4
`define SSC_ERR_PATH 5
`define SSC_ERR_OVERVOLT 6
`define SSC_ERR_UNDERVOLT 7
`define SSC_ERR_RESERVED 8
`define SSC_ERR_HALL 9
`define SSC_ERR_FIELD 10
`define SSC_ERR_ONE 11

// ****************************************************
// Timing
// ****************************************************
`define SSC_CLK_PERIOD_NS 50
`define SSC_TICK_STEP_NS 500
`define SSC_TICK_STEP_CYCLES (`SSC_TICK_STEP_NS / `SSC_CLK_PERIOD_NS)
`define SSC_TICK_CODE_MAX 5'h17
`define SSC_LOW_3 3'h3
`define SSC_LOW_5 3'h5
`define SSC_LOW_6 3'h6

// ****************************************************
// Constant-length pause frame lengths in ticks
// ****************************************************
`define SSC_FRAME_0000 9'h138
`define SSC_FRAME_1000 9'h0e1
`define SSC_FRAME_1001 9'h0ef
`define SSC_FRAME_1010 9'h0fa
`define SSC_FRAME_1011 9'h10d
`define SSC_FRAME_1100 9'h126
`define SSC_FRAME_1101 9'h16e
`define SSC_FRAME_1110 9'h177
`define SSC_FRAME_1111 9'h1c2

`endif

// ===== src/ssc_pkg.sv
// Types shared by the slow-channel sequencer files
package ssc_pkg;
    typedef logic [7:0] ssc_id_type;
    typedef logic [11:0] ssc_data_type;
    typedef logic [2:0] ssc_index_type;
    typedef enum logic [1:0]
    {
        SSC_PH_STARTUP = 2'b00,
        SSC_PH_RUN = 2'b01
    } ssc_phase_type;
endpackage

// ===== src/ssc_fifo.sv
// Shift-register FIFO whose head entry sits in flip-flops
module ssc_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [DEPTH-1:0] full_slot;
    logic push;
    logic pop;
    logic [DEPTH-1:0] next_full_slot;

    // ****************************************************
    // Handshakes
    // ****************************************************
    // Ready is the top slot's emptiness, so it never lies about room
    assign in_ready = ~full_slot[DEPTH-1];
    assign out_valid = full_slot[0];
    assign out_data = mem[0];
    assign push = in_valid & ~full_slot[DEPTH-1];
    assign pop = out_ready & full_slot[0];

    // ****************************************************
    // Storage
    // ****************************************************
    // Occupancy after shift and fill
    always_comb
    begin
        next_full_slot = full_slot;
        if (pop)
        begin
            next_full_slot = {1'b0, full_slot[DEPTH-1:1]};
        end
        if (push)
        begin
            next_full_slot = {next_full_slot[DEPTH-2:0], 1'b1};
        end
    end

    // Valid bits form a thermometer from slot 0 upward
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            full_slot <= '0;
        end
        else
        begin
            full_slot <= next_full_slot;
        end
    end

    // Entries shift toward the head; new word lands in first free slot
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                if (push && next_full_slot[i] &&
                    (i == DEPTH-1 || !next_full_slot[(i+1) % DEPTH]))
                begin
                    mem[i] <= in_data;
                end
                else if (pop && i < DEPTH-1)
                begin
                    mem[i] <= mem[(i+1) % DEPTH];
                end
            end
        end
    end
endmodule

// ===== src/ssc_tick_gen.sv
// Tick divider: one-cycle enable per programmed tick time
`include "ssc_defines.svh"
module ssc_tick_gen (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [4:0] tick_code,
    output logic tick
);
    logic [7:0] count;
    logic [7:0] limit;
    logic [4:0] code_eff;

    // Codes past the top step hold at the longest tick
    assign code_eff = (tick_code > `SSC_TICK_CODE_MAX) ? `SSC_TICK_CODE_MAX : tick_code;
    assign limit = 8'((code_eff + 5'h01) * `SSC_TICK_STEP_CYCLES - 1);

    // Free-running counter; a code change applies to the tick period in progress
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= 8'h00;
            tick <= 1'b0;
        end
        else if (count >= limit)
        begin
            count <= 8'h00;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule

// ===== src/ssc_sequencer.sv
// Slow-channel message sequencer, error word, start-up and frame timing
`include "ssc_defines.svh"
module ssc_sequencer #(
    parameter logic [11:0] MAKER_CODE = 12'h0a5 // Arbitrary neutral value
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic slow_enable,
    input wire logic interleave_error,
    input wire logic [3:0] block_enable,
    input wire logic startup_4094,
    input wire logic status_err_enable,
    input wire logic field_loss_select,
    input wire logic constant_length_pause,
    input wire logic [3:0] output_rate,
    input wire logic [4:0] tick_code,
    input wire logic [1:0] low_select,
    input wire logic [15:0] customer_word_0,
    input wire logic [15:0] customer_word_1,
    input wire logic [15:0] customer_word_2,
    input wire logic [15:0] customer_word_3,
    input wire logic [15:0] customer_word_4,
    input wire logic [15:0] customer_word_5,
    input wire logic [15:0] customer_word_6,
    input wire logic [15:0] customer_word_7,
    input wire logic [15:0] customer_word_8,
    input wire logic [15:0] customer_word_9,
    input wire logic [15:0] factory_serial_word_a,
    input wire logic [15:0] factory_serial_word_b,
    input wire logic [11:0] temperature,
    input wire logic [11:0] position,
    input wire logic data_valid,
    input wire logic [9:0] fault_flags,
    input wire logic field_out_of_range,
    input wire logic path_overflow,
    input wire logic path_underflow,
    input wire logic [11:0] field_high_limit,
    input wire logic [11:0] clamp_low,
    input wire logic sample_strobe,
    input wire logic frame_done,
    input wire logic msg_ready,
    output ssc_pkg::ssc_id_type msg_id,
    output ssc_pkg::ssc_data_type msg_data,
    output logic msg_valid,
    output ssc_pkg::ssc_data_type error_word,
    output ssc_pkg::ssc_data_type fast_value,
    output logic status_error,
    output logic tick,
    output logic [2:0] low_ticks,
    output logic frame_start
);
    import ssc_pkg::*;

    ssc_index_type blk;
    ssc_index_type msg;
    logic error_turn;
    logic [4:0] blk_mask;
    ssc_index_type next_blk;
    ssc_index_type item_msg;
    logic push;
    logic fifo_ready;
    ssc_id_type item_id;
    ssc_data_type item_data;
    ssc_data_type next_error_word;
    logic class_func;
    logic class_sensor;
    ssc_phase_type phase;
    logic [8:0] frame_ticks;
    logic [8:0] tick_count;

    // ****************************************************
    // Helpers
    // ****************************************************
    // Cut one 12-bit field out of three packed 16-bit words
    function automatic ssc_data_type pack12(input logic [15:0] w0, input logic [15:0] w1,
                                            input logic [15:0] w2, input ssc_index_type k);
        logic [47:0] flat;
        flat = {w2, w1, w0};
        return flat[k*12 +: 12];
    endfunction

    // Temperature code kept inside its legal range
    function automatic ssc_data_type temp_limit(input ssc_data_type t);
        ssc_data_type r;
        r = t;
        if (t < `SSC_TEMP_MIN)
        begin
            r = `SSC_TEMP_MIN;
        end
        else if (t > `SSC_TEMP_MAX)
        begin
            r = `SSC_TEMP_MAX;
        end
        return r;
    endfunction

    // ****************************************************
    // Message sequencing
    // ****************************************************
    assign blk_mask = {block_enable, 1'b1};
    // Interleaving skips the per-block error slot
    assign item_msg = (interleave_error && msg == 3'h0) ? 3'h1 : msg;
    assign push = slow_enable & fifo_ready;

    // Next enabled block after the current one, wrapping to the first
    always_comb
    begin
        next_blk = 3'h0;
        for (int i = 4; i >= 1; i--)
        begin
            if (i > int'(blk) && blk_mask[i])
            begin
                next_blk = 3'(i);
            end
        end
    end

    // Item contents for the current slot
    always_comb
    begin
        item_id = `SSC_ID_ERROR;
        item_data = error_word;
        if (!(interleave_error && error_turn) && item_msg != 3'h0)
        begin
            unique case (blk)
                3'h0:
                begin
                    unique case (item_msg)
                        3'h1:
                        begin
                            item_id = `SSC_ID_SENSOR_TYPE;
                            item_data = customer_word_0[11:0];
                        end
                        3'h2:
                        begin
                            item_id = `SSC_ID_MAKER;
                            item_data = MAKER_CODE;
                        end
                        3'h3:
                        begin
                            item_id = `SSC_ID_REVISION;
                            item_data = `SSC_REVISION_DATA;
                        end
                        default:
                        begin
                            item_id = `SSC_ID_TEMP;
                            item_data = temp_limit(temperature);
                        end
                    endcase
                end
                3'h1:
                begin
                    item_id = `SSC_ID_SERIAL_BASE + 8'(item_msg - 3'h1);
                    unique case (item_msg)
                        3'h1: item_data = {4'h0, factory_serial_word_a[15:8]};
                        3'h2: item_data = {4'h0, factory_serial_word_a[7:0]};
                        3'h3: item_data = {4'h0, factory_serial_word_b[15:8]};
                        default: item_data = {4'h0, factory_serial_word_b[7:0]};
                    endcase
                end
                3'h2:
                begin
                    item_id = `SSC_ID_CUST_BASE + 8'(item_msg - 3'h1);
                    item_data = pack12(customer_word_1, customer_word_2, customer_word_3,
                                       item_msg - 3'h1);
                end
                3'h3:
                begin
                    item_id = `SSC_ID_OEM_A_BASE + 8'(item_msg - 3'h1);
                    item_data = pack12(customer_word_4, customer_word_5, customer_word_6,
                                       item_msg - 3'h1);
                end
                default:
                begin
                    item_id = `SSC_ID_OEM_B_BASE + 8'(item_msg - 3'h1);
                    item_data = pack12(customer_word_7, customer_word_8, customer_word_9,
                                       item_msg - 3'h1);
                end
            endcase
        end
    end

    // Slot position; held at the start while the channel is off
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            blk <= 3'h0;
            msg <= 3'h0;
            error_turn <= 1'b1;
        end
        else if (!slow_enable)
        begin
            blk <= 3'h0;
            msg <= 3'h0;
            error_turn <= 1'b1;
        end
        else if (push)
        begin
            if (interleave_error && error_turn)
            begin
                error_turn <= 1'b0;
            end
            else
            begin
                error_turn <= 1'b1;
                if (item_msg == 3'h4 || !blk_mask[blk])
                begin
                    blk <= next_blk;
                    msg <= 3'h0;
                end
                else
                begin
                    msg <= item_msg + 3'h1;
                end
            end
        end
    end

    // Small buffer decouples the pattern from the frame shifter
    ssc_fifo #(.WIDTH(20), .DEPTH(4)) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data({item_id, item_data}),
        .out_valid(msg_valid),
        .out_ready(msg_ready),
        .out_data({msg_id, msg_data})
    );

    // ****************************************************
    // Error word and fast-channel value
    // ****************************************************
    // Bit 10 is masked when field loss is reported another way
    always_comb
    begin
        next_error_word = {2'b10, fault_flags};
        next_error_word[`SSC_ERR_ONE] = 1'b1;
        next_error_word[`SSC_ERR_FIELD] = field_out_of_range & ~field_loss_select;
        next_error_word[`SSC_ERR_RESERVED] = 1'b0;
        next_error_word[`SSC_ERR_PATH] = path_overflow | path_underflow;
    end

    assign class_func = next_error_word[`SSC_ERR_MEMORY] | next_error_word[`SSC_ERR_CONVERTER] |
                        next_error_word[`SSC_ERR_REGULATOR] | next_error_word[`SSC_ERR_TEMP] |
                        next_error_word[`SSC_ERR_HALL];
    assign class_sensor = next_error_word[`SSC_ERR_CLIPPING] |
                          next_error_word[`SSC_ERR_OVERVOLT] |
                          next_error_word[`SSC_ERR_UNDERVOLT] |
                          next_error_word[`SSC_ERR_FIELD];

    // Start-up phase ends on the first valid measurement
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase <= SSC_PH_STARTUP;
        end
        else if (data_valid)
        begin
            phase <= SSC_PH_RUN;
        end
    end

    // Functional faults outrank sensor faults, which outrank clamping
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            error_word <= 12'h800;
            fast_value <= `SSC_CODE_ZERO;
            status_error <= 1'b0;
        end
        else
        begin
            error_word <= next_error_word;
            if (phase == SSC_PH_STARTUP)
            begin
                fast_value <= startup_4094 ? `SSC_CODE_START : `SSC_CODE_ZERO;
                status_error <= status_err_enable;
            end
            else
            begin
                status_error <= status_err_enable & (class_func | class_sensor);
                if (class_func)
                begin
                    fast_value <= `SSC_CODE_FUNC;
                end
                else if (class_sensor)
                begin
                    fast_value <= `SSC_CODE_SENSOR;
                end
                else if (path_overflow)
                begin
                    fast_value <= field_high_limit;
                end
                else if (path_underflow)
                begin
                    fast_value <= clamp_low;
                end
                else
                begin
                    fast_value <= position;
                end
            end
        end
    end

    // ****************************************************
    // Tick, low time and frame timing
    // ****************************************************
    ssc_tick_gen u_tick (
        .clk(clk),
        .nrst(nrst),
        .tick_code(tick_code),
        .tick(tick)
    );

    // Unused code falls back to the shortest low time
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            low_ticks <= `SSC_LOW_3;
        end
        else
        begin
            unique case (low_select)
                2'b01: low_ticks <= `SSC_LOW_5;
                2'b10: low_ticks <= `SSC_LOW_6;
                default: low_ticks <= `SSC_LOW_3;
            endcase
        end
    end

    // Frame length in ticks for the tick-related rate codes
    always_comb
    begin
        unique case (output_rate)
            4'b1000: frame_ticks = `SSC_FRAME_1000;
            4'b1001: frame_ticks = `SSC_FRAME_1001;
            4'b1010: frame_ticks = `SSC_FRAME_1010;
            4'b1011: frame_ticks = `SSC_FRAME_1011;
            4'b1100: frame_ticks = `SSC_FRAME_1100;
            4'b1101: frame_ticks = `SSC_FRAME_1101;
            4'b1110: frame_ticks = `SSC_FRAME_1110;
            4'b1111: frame_ticks = `SSC_FRAME_1111;
            default: frame_ticks = `SSC_FRAME_0000;
        endcase
    end

    // With constant-length pause on, sampling-aligned codes start frames on each new sample
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_count <= 9'h000;
            frame_start <= 1'b0;
        end
        else if (!constant_length_pause)
        begin
            tick_count <= 9'h000;
            frame_start <= frame_done;
        end
        else if (output_rate != 4'h0 && output_rate[3] == 1'b0)
        begin
            tick_count <= 9'h000;
            frame_start <= sample_strobe;
        end
        else if (tick)
        begin
            frame_start <= (tick_count == frame_ticks - 9'h001);
            tick_count <= (tick_count >= frame_ticks - 9'h001) ? 9'h000 : tick_count + 9'h001;
        end
        else
        begin
            frame_start <= 1'b0;
        end
    end
endmodule

// ===== tb/ssc_seq_props.sv
// Checker bound to the sequencer ports
module ssc_seq_props (
    input logic clk,
    input logic nrst,
    input logic msg_valid,
    input logic msg_ready,
    input logic [7:0] msg_id,
    input logic [11:0] msg_data,
    input logic [9:0] fault_flags,
    input logic field_out_of_range,
    input logic field_loss_select,
    input logic [11:0] error_word,
    input logic [11:0] fast_value,
    input logic data_valid,
    input logic startup_4094,
    input logic status_err_enable,
    input logic status_error,
    input logic [1:0] low_select,
    input logic [2:0] low_ticks,
    input logic tick
);
    timeunit 1ns / 1ns;
    logic seen;
    // Set by the first valid sample
    always_ff @(posedge clk or negedge nrst)
        seen <= nrst & (seen | data_valid);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_err_top_one: assert property (error_word[11])
        else $error("bit 11 low");
    a_err_bits_follow: assert property ($past(nrst) |->
        (error_word[9:0] & 10'h3df) == $past(fault_flags & 10'h2df))
        else $error("fault bits wrong");
    a_field_gate: assert property ($past(nrst) |->
        error_word[10] == $past(field_out_of_range & !field_loss_select))
        else $error("bit 10 wrong");
    a_low_map: assert property ($past(nrst) |-> low_ticks == (($past(low_select) == 2'h1) ?
        3'h5 : ($past(low_select) == 2'h2) ? 3'h6 : 3'h3))
        else $error("low ticks wrong");
    a_tick_single: assert property (tick |=> !tick)
        else $error("tick too long");
    a_msg_hold: assert property (msg_valid && !msg_ready |=>
        msg_valid && $stable({msg_id, msg_data}))
        else $error("head changed");
    a_temp_range: assert property (msg_valid && msg_id == 8'h23 |->
        msg_data inside {[12'h001:12'hff8]})
        else $error("temp range");
    a_startup_value: assert property (!seen && $past(nrst) |->
        fast_value == ($past(startup_4094) ? 12'hffe : 12'h000) &&
        status_error == $past(status_err_enable))
        else $error("start-up wrong");
    c_last_oem: cover property (msg_valid && msg_ready && msg_id == 8'h97);
    c_startup_high: cover property (!seen && fast_value == 12'hffe);
    c_stalled: cover property (msg_valid && !msg_ready);
endmodule
bind ssc_sequencer ssc_seq_props u_props (.*);

// ===== tb/ssc_ecu_model.sv
// Receiving control unit model; may stall
module ssc_ecu_model (
    input logic clk,
    input logic nrst,
    input logic slow_rx,
    input logic msg_valid,
    input logic [7:0] msg_id,
    input logic [11:0] msg_data,
    output logic msg_ready
);
    timeunit 1ns / 1ns;
    logic [1:0] pace;
    logic [19:0] rx[$];
    // Ready always, or one cycle in four
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pace <= 2'h0;
            msg_ready <= 1'h0;
            rx.delete();
        end
        else
        begin
            pace <= pace + 2'h1;
            msg_ready <= !slow_rx || pace == 2'h3;
            if (msg_valid && msg_ready)
                rx.push_back({msg_id, msg_data});
        end
    end
endmodule

// ===== tb/testbench.sv
// Self-checking sequencer bench
module testbench;
    timeunit 1ns / 1ns;
    import ssc_pkg::*;
    localparam logic [11:0] MAKER = 12'h0a5; // Arbitrary value
    logic clk = 1'h0, nrst = 1'h0, slow_enable = 1'h1, interleave_error = 1'h0, slow_rx = 1'h0;
    logic startup_4094 = 1'h0, status_err_enable = 1'h0, field_loss_select = 1'h0;
    logic constant_length_pause = 1'h1, data_valid = 1'h0, field_out_of_range = 1'h0;
    logic path_overflow = 1'h0, path_underflow = 1'h0, sample_strobe = 1'h0, frame_done = 1'h0;
    logic [3:0] block_enable = 4'h0, output_rate = 4'h1;
    logic [4:0] tick_code = 5'h00;
    logic [1:0] low_select = 2'h0;
    logic [15:0] customer_word_0 = 16'h7055, customer_word_1 = 16'h3c21, customer_word_2 = 16'h9d4e;
    logic [15:0] customer_word_3 = 16'h1f86, customer_word_4 = 16'h4241, customer_word_5 = 16'h4443;
    logic [15:0] customer_word_6 = 16'h4645, customer_word_7 = 16'h5a59, customer_word_8 = 16'h3130;
    logic [15:0] customer_word_9 = 16'h3332, factory_serial_word_a = 16'hab12;
    logic [15:0] factory_serial_word_b = 16'hcd34;
    logic [11:0] temperature = 12'hfff, position = 12'h123, field_high_limit = 12'hf00;
    logic [11:0] clamp_low = 12'h010;
    logic [9:0] fault_flags = 10'h000;
    ssc_id_type msg_id;
    ssc_data_type msg_data, error_word, fast_value;
    logic msg_valid, msg_ready, status_error, tick, frame_start;
    logic [2:0] low_ticks;
    int bad_count = 0, num_checks = 0;
    logic [19:0] ex[$];
    ssc_sequencer #(.MAKER_CODE(MAKER)) DUT (.*);
    ssc_ecu_model ecu (.*);
    // 20 MHz clock
    always #25 clk = ~clk;
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [19:0] got, want);
        num_checks++;
        if (got !== want)
        begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask
    task rst;
        nrst <= 1'h0;
        repeat (5) @(posedge clk);
        nrst <= 1'h1;
    endtask
    // Error word leads each item when interleaving
    task it(input logic [7:0] id, logic [11:0] d);
        if (interleave_error)
            ex.push_back({8'h01, 12'h800});
        ex.push_back({id, d});
    endtask
    task blk(input int b);
        logic [47:0] p;
        p = b == 2 ? {16'h0, factory_serial_word_a, factory_serial_word_b} : b == 3 ?
            {customer_word_3, customer_word_2, customer_word_1} : b == 4 ?
            {customer_word_6, customer_word_5, customer_word_4} :
            {customer_word_9, customer_word_8, customer_word_7};
        if (!interleave_error)
            ex.push_back({8'h01, 12'h800});
        if (b == 1)
        begin
            it(8'h03, customer_word_0[11:0]);
            it(8'h05, MAKER);
            it(8'h06, 12'h004);
            it(8'h23, temperature == 12'h000 ? 12'h001 : temperature > 12'hff8 ? 12'hff8 : temperature);
        end
        else
            for (int k = 0; k < 4; k++)
            begin
                if (b == 2)
                    it(8'h29 + 8'(k), {4'h0, p[31 - 8 * k -: 8]});
                else
                    it((b == 3 ? 8'h07 : b == 4 ? 8'h90 : 8'h94) + 8'(k), p[12 * k +: 12]);
            end
    endtask
    // Bounded wait, then in-order compare
    task expect_rx;
        for (int i = 0; ecu.rx.size() < ex.size() && i < 3000; i++)
            @(posedge clk);
        foreach (ex[k])
            chk(ecu.rx[k], ex[k]);
        ex.delete();
    endtask
    task t_blocks;
        rst;
        blk(1); blk(1);
        expect_rx;
        block_enable <= 4'hf;
        slow_rx <= 1'h1;
        rst;
        for (int b = 1; b <= 5; b++) blk(b);
        blk(1);
        expect_rx;
        block_enable <= 4'h5;
        rst;
        blk(1); blk(2); blk(4); blk(1);
        expect_rx;
    endtask
    task t_interleave;
        interleave_error <= 1'h1;
        block_enable <= 4'h1;
        temperature <= 12'h000;
        rst;
        blk(1); blk(2); blk(1);
        expect_rx;
        interleave_error <= 1'h0;
        slow_enable <= 1'h0;
        rst;
        repeat (20) @(posedge clk);
        chk(20'(msg_valid), 20'h0);
        chk(20'(ecu.rx.size()), 20'h0);
        slow_enable <= 1'h1;
    endtask
    task t_startup;
        startup_4094 <= 1'h1;
        status_err_enable <= 1'h1;
        rst;
        repeat (3) @(negedge clk);
        chk({7'h0, status_error, fast_value}, {8'h1, 12'hffe});
        startup_4094 <= 1'h0;
        repeat (2) @(negedge clk);
        chk({7'h0, status_error, fast_value}, {8'h1, 12'h000});
        data_valid <= 1'h1;
        repeat (3) @(negedge clk);
        chk({7'h0, status_error, fast_value}, {8'h0, position});
    endtask
    task fault(input logic [9:0] f, logic [2:0] o, logic [11:0] ew, fv);
        @(posedge clk);
        fault_flags <= f;
        {field_out_of_range, path_overflow, path_underflow} <= o;
        repeat (2) @(negedge clk);
        chk({status_error, 7'h0, error_word}, {fv >= 12'hffa, 7'h0, ew});
        chk(20'(fast_value), 20'(fv));
    endtask
    task t_faults;
        fault(10'h001, 3'h0, 12'h801, 12'hffa);
        fault(10'h006, 3'h0, 12'h806, 12'hffa);
        fault(10'h048, 3'h0, 12'h848, 12'hffb);
        fault(10'h090, 3'h0, 12'h890, 12'hffa);
        fault(10'h100, 3'h0, 12'h800, 12'h123);
        fault(10'h200, 3'h0, 12'ha00, 12'hffa);
        fault(10'h000, 3'h2, 12'h820, 12'hf00);
        fault(10'h000, 3'h1, 12'h820, 12'h010);
        fault(10'h000, 3'h4, 12'hc00, 12'hffb);
        field_loss_select <= 1'h1;
        fault(10'h000, 3'h4, 12'h800, 12'h123);
    endtask
    task gap(input bit fs, int want);
        int n;
        repeat (2)
        begin
            n = 0;
            do @(negedge clk);
            while (++n < 5000 && (fs ? frame_start : tick) !== 1'h1);
        end
        chk(20'(n), 20'(want));
    endtask
    task strobe(input bit d);
        @(posedge clk);
        {frame_done, sample_strobe} <= {d, !d};
        @(posedge clk);
        {frame_done, sample_strobe} <= 2'h0;
        @(negedge clk);
        chk(20'(frame_start), 20'h1);
    endtask
    task t_timing;
        for (int s = 0; s < 4; s++)
        begin
            low_select <= 2'(s);
            repeat (2) @(posedge clk);
        end
        gap(1'h0, 10);
        tick_code <= 5'h1f;
        gap(1'h0, 240);
        tick_code <= 5'h00;
        strobe(1'h0);
        output_rate <= 4'h8;
        gap(1'h1, 2250);
        constant_length_pause <= 1'h0;
        strobe(1'h1);
    endtask
    // Hang guard
    initial
    begin
        #2_000_000;
        bad_count++;
        print_verdict;
    end
    initial
    begin
        rst;
        t_blocks;
        t_interleave;
        t_startup;
        t_faults;
        t_timing;
        print_verdict;
    end
endmodule
